// ---- design/rx_freq_meter.sv ----
// measures link clock rate from a synchronised toggle per link cycle
// assumes the toggle input is already two-flop synchronised
`timescale 1ns/100ps
`include "rx_status_params.svh"
module rx_freq_meter #(
    parameter int WINDOW_CYCLES = 32000
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // sampled link toggle
    input wire logic tick_in,
    // result
    output logic [15:0] rate_out
);
    // counts edges in a window of 256 us at 125 MHz, giving 1/256 MHz units
    initial begin
        if (WINDOW_CYCLES < 2) begin
            $error("WINDOW_CYCLES too small");
        end
    end
    logic [31:0] win_q;
    logic [15:0] edges_q;
    logic tick_prev_q;
    wire win_end = win_q == 32'(WINDOW_CYCLES - 1);
    wire edge_seen = tick_in != tick_prev_q;
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            win_q <= 32'h00000000;
            edges_q <= 16'h0000;
            tick_prev_q <= 1'b0;
            rate_out <= 16'h0000;
        end else begin
            tick_prev_q <= tick_in;
            win_q <= win_end ? 32'h00000000 : win_q + 32'h00000001;
            if (win_end) begin
                rate_out <= edges_q;
                // edge in the closing cycle opens the next window
                edges_q <= {15'h0000, edge_seen};
            end else if (edge_seen && !(&edges_q)) begin
                edges_q <= edges_q + 16'h0001;
            end
        end
    end
endmodule

// ---- design/rx_port_link_status_bank.sv ----
// per-port status register bank of a dual receive-port deserializer hub
// Functional notes
// - per-port copies chosen by port-select register
// - status one bit 6 reads selected port
// - control channel CRC error flag, clear-on-read
// - lock change flag, clear-on-read
// - control channel sequence error, clear-on-read
// - parity count above limit, clears with counters
// - live pass indication per pass criteria
// - live receiver lock status
// - line length unsteady, held until read
// - line length change flag, clear-on-read
// - link encoding fault flag, clear-on-read
// - packet buffer overflow flag, clear-on-read
// - summary of video receive fault detail
// - cable fault when no link clock
// - line count change flag, clear-on-read
// - frequency integer megahertz byte, read-only
// - frequency fraction byte in 1/256 MHz
// - parity counters restart on lock or low-byte read
// assumes a simple register port: address, write strobe, read strobe, data
`timescale 1ns/100ps
`include "rx_status_params.svh"
module rx_port_link_status_bank #(
    parameter int PORTS = 2,
    parameter int WINDOW_CYCLES = 32000
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // port 0 events
    input wire rx_status_pkg::port_events_t port0_ev_in,
    input wire logic port0_link_tick_in,
    // port 1 events
    input wire rx_status_pkg::port_events_t port1_ev_in,
    input wire logic port1_link_tick_in,
    // configuration from elsewhere in the device
    input wire logic [15:0] parity_limit_setting_in
);
    initial begin
        if (PORTS != 2) begin
            $error("bank supports exactly two ports");
        end
    end

    // ****************************************
    // port page selector
    // ****************************************
    logic read_port_q;
    logic [1:0] write_en_q;
    wire sel_hit = reg_addr_in == `PORT_SEL_OFFSET;
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            read_port_q <= 1'b0;
            write_en_q <= 2'b00;
        end else if (reg_wr_in && sel_hit) begin
            read_port_q <= reg_wdata_in[`SEL_READ_PORT_BIT];
            write_en_q <= {reg_wdata_in[`SEL_WRITE_P1_BIT], reg_wdata_in[`SEL_WRITE_P0_BIT]};
        end
    end
    wire [7:0] sel_value = {3'b000, read_port_q, 2'b00, write_en_q};

    // ****************************************
    // per-port engines
    // ****************************************
    rx_status_pkg::port_events_t ev [2];
    logic tick_meta_q [2];
    logic tick_sync_q [2];
    logic [15:0] rate [2];
    logic [7:0] s1 [2];
    logic [7:0] s2 [2];
    logic [15:0] pc [2];
    assign ev[0] = port0_ev_in;
    assign ev[1] = port1_ev_in;
    wire [1:0] tick_raw = {port1_link_tick_in, port0_link_tick_in};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_port
            rx_status_if sif();
            wire mine = read_port_q == 1'(g);
            // reads clear only the selected port's flags
            assign sif.rd_one = reg_rd_in && mine && reg_addr_in == `STATUS_ONE_OFFSET;
            assign sif.rd_two = reg_rd_in && mine && reg_addr_in == `STATUS_TWO_OFFSET;
            assign sif.rd_par_lo = reg_rd_in && mine && reg_addr_in == `PAR_LO_OFFSET;
            assign s1[g] = sif.status_one;
            assign s2[g] = sif.status_two;
            assign pc[g] = sif.par_count;

            always_ff @(posedge clock_in) begin
                if (srst_in) begin
                    tick_meta_q[g] <= 1'b0;
                    tick_sync_q[g] <= 1'b0;
                end else begin
                    tick_meta_q[g] <= tick_raw[g];
                    tick_sync_q[g] <= tick_meta_q[g];
                end
            end

            rx_port_status #(
                .PAR_WIDTH(16)
            ) u_status (
                .clock_in(clock_in),
                .srst_in(srst_in),
                .ev_in(ev[g]),
                .parity_limit_setting_in(parity_limit_setting_in),
                .bus(sif.port)
            );

            rx_freq_meter #(
                .WINDOW_CYCLES(WINDOW_CYCLES)
            ) u_freq (
                .clock_in(clock_in),
                .srst_in(srst_in),
                .tick_in(tick_sync_q[g]),
                .rate_out(rate[g])
            );
        end
    endgenerate

    // ****************************************
    // read mux
    // ****************************************
    wire [7:0] s1_sel = s1[read_port_q] | {1'b0, read_port_q, 6'h00};
    wire [7:0] s2_sel = s2[read_port_q];
    wire [15:0] rate_sel = rate[read_port_q];
    wire [15:0] pc_sel = pc[read_port_q];
    logic [7:0] rdata_d;
    always_comb begin
        unique case (reg_addr_in)
            `PORT_SEL_OFFSET: rdata_d = sel_value;
            `STATUS_ONE_OFFSET: rdata_d = s1_sel;
            `STATUS_TWO_OFFSET: rdata_d = s2_sel;
            `FREQ_INT_OFFSET: rdata_d = rate_sel[15:8];
            `FREQ_FRAC_OFFSET: rdata_d = rate_sel[7:0];
            `PAR_HI_OFFSET: rdata_d = pc_sel[15:8];
            `PAR_LO_OFFSET: rdata_d = pc_sel[7:0];
            default: rdata_d = 8'h00;
        endcase
    end
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            reg_rdata_out <= `STATUS_RESET;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rdata_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_port_num;
        @(posedge clock_in) disable iff (srst_in)
        (reg_rd_in && reg_addr_in == `STATUS_ONE_OFFSET) |=>
            reg_rdata_out[`S1_PORT_NUM_BIT] == $past(read_port_q);
    endproperty
    a_port_num: assert property (p_port_num) else $error("port number wrong");

    property p_lock_live;
        @(posedge clock_in) disable iff (srst_in)
        (reg_rd_in && reg_addr_in == `STATUS_ONE_OFFSET && !read_port_q) |=>
            reg_rdata_out[`S1_LOCK_BIT] == $past(port0_ev_in.locked);
    endproperty
    a_lock_live: assert property (p_lock_live) else $error("lock bit wrong");

    property p_pass_live;
        @(posedge clock_in) disable iff (srst_in)
        (reg_rd_in && reg_addr_in == `STATUS_ONE_OFFSET && read_port_q) |=>
            reg_rdata_out[`S1_PASS_BIT] == $past(port1_ev_in.pass);
    endproperty
    a_pass_live: assert property (p_pass_live) else $error("pass bit wrong");

    property p_cable;
        @(posedge clock_in) disable iff (srst_in)
        (reg_rd_in && reg_addr_in == `STATUS_TWO_OFFSET && !read_port_q) |=>
            reg_rdata_out[`S2_CABLE_BIT] == $past(port0_ev_in.cable_fault)
            && reg_rdata_out[`S2_CSI_BIT] == $past(port0_ev_in.csi_err);
    endproperty
    a_cable: assert property (p_cable) else $error("cable or csi bit wrong");

    property p_sel_write;
        @(posedge clock_in) disable iff (srst_in)
        (reg_wr_in && sel_hit) |=> read_port_q == $past(reg_wdata_in[`SEL_READ_PORT_BIT]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("port select not taken");
endmodule

// ---- design/rx_port_status.sv ----
// sticky status flags and parity counter for one receive port
// assumes event inputs are synchronous to clock_in
`timescale 1ns/100ps
`include "rx_status_params.svh"
module rx_port_status #(
    parameter int PAR_WIDTH = 16
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // hardware events
    input wire rx_status_pkg::port_events_t ev_in,
    input wire logic [15:0] parity_limit_setting_in,
    // bank side
    rx_status_if.port bus
);
    initial begin
        if (PAR_WIDTH != 16) begin
            $error("PAR_WIDTH must be 16");
        end
    end

    // ****************************************
    // sticky flags
    // ****************************************
    logic crc_q, lock_chg_q, seq_q, unsteady_q, len_chg_q, enc_q, buf_q, cnt_chg_q;
    logic lock_prev_q;
    logic [15:0] par_q;
    wire lock_edge = ev_in.locked != lock_prev_q;
    wire lock_rise = ev_in.locked & ~lock_prev_q;

    // set wins over the clearing read
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            crc_q <= 1'b0;
            lock_chg_q <= 1'b0;
            seq_q <= 1'b0;
            lock_prev_q <= 1'b0;
        end else begin
            lock_prev_q <= ev_in.locked;
            crc_q <= ev_in.crc_err | (crc_q & ~bus.rd_one);
            lock_chg_q <= lock_edge | (lock_chg_q & ~bus.rd_one);
            seq_q <= ev_in.seq_err | (seq_q & ~bus.rd_one);
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            unsteady_q <= 1'b0;
            len_chg_q <= 1'b0;
            enc_q <= 1'b0;
            buf_q <= 1'b0;
            cnt_chg_q <= 1'b0;
        end else begin
            unsteady_q <= ev_in.len_unsteady | (unsteady_q & ~bus.rd_two);
            len_chg_q <= ev_in.len_chg | (len_chg_q & ~bus.rd_two);
            enc_q <= ev_in.encode_err | (enc_q & ~bus.rd_two);
            buf_q <= ev_in.buffer_ovf | (buf_q & ~bus.rd_two);
            cnt_chg_q <= ev_in.line_total_change_flag | (cnt_chg_q & ~bus.rd_two);
        end
    end

    // ****************************************
    // parity counter, restarts on lock or low-byte read
    // ****************************************
    wire par_restart = lock_rise | bus.rd_par_lo;
    wire par_sat = &par_q;
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            par_q <= `PAR_COUNT_RESET;
        end else if (par_restart) begin
            par_q <= {15'h0000, ev_in.parity_err};
        end else if (ev_in.parity_err && !par_sat) begin
            par_q <= par_q + 16'h0001;
        end
    end

    assign bus.par_count = par_q;
    assign bus.parity_flag = par_q > parity_limit_setting_in;
    assign bus.status_one = {2'b00, crc_q, lock_chg_q, seq_q, par_q > parity_limit_setting_in,
        ev_in.pass, ev_in.locked};
    assign bus.status_two = {unsteady_q, len_chg_q, enc_q, buf_q, ev_in.csi_err,
        ev_in.measured_rate_settled, ev_in.cable_fault, cnt_chg_q};

    // ****************************************
    // checks
    // ****************************************
    property p_crc_hold;
        @(posedge clock_in) disable iff (srst_in)
        ev_in.crc_err |=> bus.status_one[`S1_CRC_BIT];
    endproperty
    a_crc_hold: assert property (p_crc_hold) else $error("crc flag not set");

    property p_lock_chg;
        @(posedge clock_in) disable iff (srst_in)
        (ev_in.locked != $past(ev_in.locked)) |=> bus.status_one[`S1_LOCK_CHG_BIT];
    endproperty
    a_lock_chg: assert property (p_lock_chg) else $error("lock change missed");

    property p_seq_clear;
        @(posedge clock_in) disable iff (srst_in)
        (bus.rd_one && !ev_in.seq_err) |=> !bus.status_one[`S1_SEQ_BIT];
    endproperty
    a_seq_clear: assert property (p_seq_clear) else $error("seq flag not cleared");

    property p_len_race;
        @(posedge clock_in) disable iff (srst_in)
        (bus.rd_two && ev_in.len_chg) |=> bus.status_two[`S2_LEN_CHG_BIT];
    endproperty
    a_len_race: assert property (p_len_race) else $error("event lost on read");

    property p_unsteady_stay;
        @(posedge clock_in) disable iff (srst_in)
        (bus.status_two[`S2_LEN_UNSTEADY_BIT] && !bus.rd_two) |=>
            bus.status_two[`S2_LEN_UNSTEADY_BIT];
    endproperty
    a_unsteady_stay: assert property (p_unsteady_stay) else $error("unsteady dropped");

    property p_enc;
        @(posedge clock_in) disable iff (srst_in)
        ev_in.encode_err ##1 !bus.rd_two |=> bus.status_two[`S2_ENCODE_BIT];
    endproperty
    a_enc: assert property (p_enc) else $error("encode flag lost");

    property p_buf;
        @(posedge clock_in) disable iff (srst_in)
        ev_in.buffer_ovf |=> bus.status_two[`S2_BUFFER_BIT];
    endproperty
    a_buf: assert property (p_buf) else $error("buffer flag not set");

    property p_cnt;
        @(posedge clock_in) disable iff (srst_in)
        ev_in.line_total_change_flag |=> bus.status_two[`S2_LINE_CNT_BIT];
    endproperty
    a_cnt: assert property (p_cnt) else $error("line count flag not set");

    property p_par_restart;
        @(posedge clock_in) disable iff (srst_in)
        (bus.rd_par_lo && !ev_in.parity_err) |=> (bus.par_count == 16'h0000) && !bus.parity_flag;
    endproperty
    a_par_restart: assert property (p_par_restart) else $error("parity not restarted");
endmodule

// ---- design/rx_status_if.sv ----
// carrier between the bank top and one per-port status engine
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface rx_status_if;
    logic rd_one;
    logic rd_two;
    logic rd_par_lo;
    logic [7:0] status_one;
    logic [7:0] status_two;
    logic [15:0] par_count;
    logic parity_flag;
    modport bank(output rd_one, output rd_two, output rd_par_lo,
        input status_one, input status_two, input par_count, input parity_flag);
    modport port(input rd_one, input rd_two, input rd_par_lo,
        output status_one, output status_two, output par_count, output parity_flag);
endinterface

// ---- design/rx_status_params.svh ----
// register offsets, field positions, reset values for the rx port status bank
// included by the design modules of the status bank
`ifndef RX_STATUS_PARAMS_SVH
`define RX_STATUS_PARAMS_SVH

// ****************************************
// offsets
// ****************************************
`define PORT_SEL_OFFSET 8'h4C
`define STATUS_ONE_OFFSET 8'h4D
`define STATUS_TWO_OFFSET 8'h4E
`define FREQ_INT_OFFSET 8'h4F
`define FREQ_FRAC_OFFSET 8'h50
`define PAR_HI_OFFSET 8'h55
`define PAR_LO_OFFSET 8'h56

// ****************************************
// port select fields
// ****************************************
`define SEL_READ_PORT_BIT 4
`define SEL_WRITE_P1_BIT 1
`define SEL_WRITE_P0_BIT 0

// ****************************************
// status one fields
// ****************************************
`define S1_PORT_NUM_BIT 6
`define S1_CRC_BIT 5
`define S1_LOCK_CHG_BIT 4
`define S1_SEQ_BIT 3
`define S1_PARITY_BIT 2
`define S1_PASS_BIT 1
`define S1_LOCK_BIT 0

// ****************************************
// status two fields
// ****************************************
`define S2_LEN_UNSTEADY_BIT 7
`define S2_LEN_CHG_BIT 6
`define S2_ENCODE_BIT 5
`define S2_BUFFER_BIT 4
`define S2_CSI_BIT 3
`define S2_RATE_SETTLED_BIT 2
`define S2_CABLE_BIT 1
`define S2_LINE_CNT_BIT 0

// ****************************************
// reset values
// ****************************************
`define STATUS_RESET 8'h00
`define FREQ_RESET 8'h00
`define PORT_SEL_RESET 8'h00
`define PAR_COUNT_RESET 16'h0000

`endif

// ---- design/rx_status_pkg.sv ----
// types shared by the rx port status bank
// no assumptions beyond a single register clock
package rx_status_pkg;
    // ****************************************
    // per-port hardware event and level inputs
    // ****************************************
    typedef struct packed {
        logic locked;
        logic pass;
        logic crc_err;
        logic seq_err;
        logic parity_err;
        logic len_unsteady;
        logic len_chg;
        logic encode_err;
        logic buffer_ovf;
        logic csi_err;
        logic measured_rate_settled;
        logic cable_fault;
        logic line_total_change_flag;
    } port_events_t;
endpackage

// ---- test/serializer_model.sv ----
// far-side model: remote serializer feeding one receive port
// assumes the bench drives its controls just after the rising edge
`timescale 1ns/100ps
module serializer_model (
    // clock
    input wire logic clock_in,
    // bench controls: levels {cable,csi,pass,locked}, event pulses of one or more cycles
    input wire logic [3:0] level_in,
    input wire logic [7:0] pulse_in,
    input wire logic tick_run_in,
    // receive port side
    output rx_status_pkg::port_events_t ev_out,
    output logic link_tick_out
);
    logic [1:0] div_q = 2'h0;
    // ********
    // link status and events
    // ********
    assign ev_out.locked = level_in[0];
    assign ev_out.pass = level_in[1];
    assign ev_out.csi_err = level_in[2];
    assign ev_out.cable_fault = level_in[3];
    assign ev_out.measured_rate_settled = tick_run_in;
    assign ev_out.crc_err = pulse_in[0];
    assign ev_out.seq_err = pulse_in[1];
    assign ev_out.parity_err = pulse_in[2];
    assign ev_out.len_unsteady = pulse_in[3];
    assign ev_out.len_chg = pulse_in[4];
    // encoding faults only reach the port while lock is held
    assign ev_out.encode_err = pulse_in[5] & level_in[0];
    assign ev_out.buffer_ovf = pulse_in[6];
    assign ev_out.line_total_change_flag = pulse_in[7];
    // ********
    // link clock toggle, still when the link is idle
    // ********
    assign link_tick_out = div_q[1];
    always @(posedge clock_in) begin
        if (tick_run_in) begin
            div_q <= div_q + 2'h1;
        end
    end
endmodule

// ---- test/tb_rx_port_link_status_bank.sv ----
// self-checking bench for the rx port status bank
// assumes two serializer models on the receive ports
`timescale 1ns/100ps
module tb_rx_port_link_status_bank;
    localparam int WINDOW = 640;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [7:0] reg_rdata_out;
    logic [15:0] parity_limit_setting_in = 16'h0003;
    logic [1:0][3:0] level_q = '0;
    logic [1:0][7:0] pulse_q = '0;
    logic [1:0] run_q = 2'h0;
    rx_status_pkg::port_events_t ev0;
    rx_status_pkg::port_events_t ev1;
    logic tick0;
    logic tick1;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #4 clock_in = ~clock_in;

    rx_port_link_status_bank #(.PORTS(2), .WINDOW_CYCLES(WINDOW)) i_rx_port_link_status_bank (
        .clock_in(clock_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .port0_ev_in(ev0), .port0_link_tick_in(tick0),
        .port1_ev_in(ev1), .port1_link_tick_in(tick1),
        .parity_limit_setting_in(parity_limit_setting_in));
    serializer_model i_serializer_model_p0 (.clock_in(clock_in), .level_in(level_q[0]),
        .pulse_in(pulse_q[0]), .tick_run_in(run_q[0]), .ev_out(ev0), .link_tick_out(tick0));
    serializer_model i_serializer_model_p1 (.clock_in(clock_in), .level_in(level_q[1]),
        .pulse_in(pulse_q[1]), .tick_run_in(run_q[1]), .ev_out(ev1), .link_tick_out(tick1));

    // ********
    // helpers
    // ********
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 10000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clock_in);
        #1;
        reg_addr_in = addr;
        reg_rd_in = 1'b1;
        @(posedge clock_in);
        #1;
        reg_rd_in = 1'b0;
        data = reg_rdata_out;
    endtask

    task automatic rdc(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        rd(addr, d);
        check({8'h00, d}, {8'h00, exp});
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock_in);
        #1;
        reg_addr_in = addr;
        reg_wdata_in = data;
        reg_wr_in = 1'b1;
        @(posedge clock_in);
        #1;
        reg_wr_in = 1'b0;
    endtask

    task automatic pulse(input int p, input int idx, input int n);
        @(posedge clock_in);
        #1;
        pulse_q[p][idx] = 1'b1;
        repeat (n) @(posedge clock_in);
        #1;
        pulse_q[p][idx] = 1'b0;
    endtask

    task automatic lvl(input int p, input int idx, input logic v);
        @(posedge clock_in);
        #1;
        level_q[p][idx] = v;
        repeat (3) @(posedge clock_in);
    endtask

    // ********
    // scenarios
    // ********
    task automatic test_reset;
        rdc(8'h4C, 8'h00);
        rdc(8'h4D, 8'h00);
        rdc(8'h4E, 8'h00);
        wr(8'h4D, 8'hFF);
        wr(8'h4F, 8'hFF);
        rdc(8'h4D, 8'h00);
        rdc(8'h4F, 8'h00);
        rdc(8'h60, 8'h00);
        $display("test reset done");
    endtask

    task automatic test_lock;
        lvl(0, 0, 1'b1);
        rdc(8'h4D, 8'h11);
        rdc(8'h4D, 8'h01);
        lvl(0, 0, 1'b0);
        rdc(8'h4D, 8'h10);
        lvl(0, 0, 1'b1);
        rdc(8'h4D, 8'h11);
        rdc(8'h4D, 8'h01);
        $display("test lock done");
    endtask

    task automatic test_sticky;
        logic [7:0] ad [8] = '{8'h4D, 8'h4D, 8'h00, 8'h4E, 8'h4E, 8'h4E, 8'h4E, 8'h4E};
        int bt [8] = '{5, 3, 0, 7, 6, 5, 4, 0};
        logic [7:0] b;
        for (int i = 0; i < 8; i++) begin
            if (i != 2) begin
                b = (ad[i] == 8'h4D) ? 8'h01 : 8'h00;
                pulse(0, i, 1);
                repeat (4) @(posedge clock_in);
                rdc(ad[i], b | (8'h01 << bt[i]));
                rdc(ad[i], b);
            end
        end
        $display("test sticky done");
    endtask

    task automatic test_set_wins;
        pulse(0, 0, 1);
        @(posedge clock_in);
        #1;
        reg_addr_in = 8'h4D;
        reg_rd_in = 1'b1;
        pulse_q[0][0] = 1'b1;
        @(posedge clock_in);
        #1;
        reg_rd_in = 1'b0;
        pulse_q[0][0] = 1'b0;
        check({8'h00, reg_rdata_out}, 16'h0021);
        rdc(8'h4D, 8'h21);
        rdc(8'h4D, 8'h01);
        @(posedge clock_in);
        #1;
        reg_addr_in = 8'h4E;
        reg_rd_in = 1'b1;
        pulse_q[0][4] = 1'b1;
        @(posedge clock_in);
        #1;
        reg_rd_in = 1'b0;
        pulse_q[0][4] = 1'b0;
        check({8'h00, reg_rdata_out}, 16'h0000);
        rdc(8'h4E, 8'h40);
        rdc(8'h4E, 8'h00);
        $display("test set wins done");
    endtask

    task automatic test_levels;
        lvl(0, 1, 1'b1);
        lvl(0, 2, 1'b1);
        lvl(0, 3, 1'b1);
        rdc(8'h4D, 8'h03);
        rdc(8'h4E, 8'h0A);
        rdc(8'h4E, 8'h0A);
        lvl(0, 1, 1'b0);
        lvl(0, 2, 1'b0);
        rdc(8'h4D, 8'h01);
        rdc(8'h4E, 8'h02);
        lvl(0, 3, 1'b0);
        rdc(8'h4E, 8'h00);
        $display("test levels done");
    endtask

    task automatic test_paging;
        pulse(1, 0, 1);
        rdc(8'h4D, 8'h01);
        wr(8'h4C, 8'hFF);
        rdc(8'h4C, 8'h13);
        rdc(8'h4D, 8'h60);
        rdc(8'h4D, 8'h40);
        wr(8'h4C, 8'h00);
        rdc(8'h4D, 8'h01);
        $display("test paging done");
    endtask

    task automatic test_parity;
        pulse(0, 2, 3);
        rdc(8'h4D, 8'h01);
        pulse(0, 2, 1);
        rdc(8'h4D, 8'h05);
        rdc(8'h55, 8'h00);
        rdc(8'h56, 8'h04);
        rdc(8'h4D, 8'h01);
        rdc(8'h56, 8'h00);
        pulse(0, 2, 2);
        lvl(0, 0, 1'b0);
        lvl(0, 0, 1'b1);
        rdc(8'h4D, 8'h11);
        rdc(8'h56, 8'h00);
        $display("test parity done");
    endtask

    task automatic test_freq;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [15:0] exp;
        // model toggles its link line every two clocks
        exp = 16'(WINDOW / 2);
        rdc(8'h50, 8'h00);
        @(posedge clock_in);
        #1;
        run_q[0] = 1'b1;
        repeat (3 * WINDOW) @(posedge clock_in);
        rd(8'h4F, hi);
        rd(8'h50, lo);
        check({hi, lo}, exp);
        rdc(8'h4E, 8'h04);
        wr(8'h4C, 8'h10);
        rdc(8'h4F, 8'h00);
        rdc(8'h50, 8'h00);
        wr(8'h4C, 8'h00);
        @(posedge clock_in);
        #1;
        run_q[0] = 1'b0;
        repeat (3 * WINDOW) @(posedge clock_in);
        rdc(8'h4F, 8'h00);
        rdc(8'h50, 8'h00);
        $display("test freq done");
    endtask

    initial begin
        repeat (2) @(posedge clock_in);
        #1;
        srst_in = 1'b0;
        test_reset();
        test_lock();
        test_sticky();
        test_set_wins();
        test_levels();
        test_paging();
        test_parity();
        test_freq();
        print_verdict();
    end
endmodule
